// [wfd_pkg.sv]
// Package: register map, field layout, frame constants and carrier types of the wake detector
package wfd_pkg;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses on the APB port)
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_MASK0    = 12'h000;  // Filter byte masks, one word each from here
    localparam logic [11:0] OFS_CMD      = 12'h010;
    localparam logic [11:0] OFS_OFFSET   = 12'h014;
    localparam logic [11:0] OFS_CRC01    = 12'h018;
    localparam logic [11:0] OFS_CRC23    = 12'h01c;
    localparam logic [11:0] OFS_WCSR     = 12'h020;
    localparam logic [11:0] OFS_ADDR_LO  = 12'h024;
    localparam logic [11:0] OFS_ADDR_HI  = 12'h028;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int NUM_FILTERS   = 4;
    localparam int MASK_BITS     = 31;
    localparam int CMD_EN_BIT    = 0;
    localparam int CMD_MCAST_BIT = 3;
    localparam int CMD_STRIDE    = 8;
    localparam int OFS_STRIDE    = 8;
    localparam int CRC_STRIDE    = 16;
    localparam int WCSR_MAGIC_PACKET_ENABLE     = 1;
    localparam int WCSR_WAKE_FRAME_ENABLE     = 2;
    localparam int WCSR_MPR      = 4;
    localparam int WCSR_WAKE_FRAME_RECEIVED_FLAG     = 5;
    localparam int WCSR_MP_IRQ   = 8;
    localparam int WCSR_MP_PME   = 9;
    localparam int WCSR_WF_IRQ   = 10;
    localparam int WCSR_WF_PME   = 11;

    // ---------------------------------------------------------------
    // Reset values and frame constants
    // ---------------------------------------------------------------
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    localparam logic [15:0] CRC_PRESET     = 16'hffff;
    localparam logic [15:0] CRC_POLY       = 16'h8005;
    localparam logic [7:0]  PAT_MIN_OFFSET = 8'h0c;
    localparam logic [10:0] HDR_LEN        = 11'h00c;
    localparam logic [10:0] DA_LEN         = 11'h006;
    localparam logic [10:0] POS_MAX        = 11'h7ff;
    localparam logic [7:0]  SYNC_BYTE      = 8'hff;
    localparam int          SYNC_LEN       = 6;
    localparam int          MAGIC_REPS     = 16;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } wfd_rx_byte_type;

    typedef enum logic [1:0] {
        MP_IDLE = 2'b00,
        MP_SYNC = 2'b01,
        MP_ADDR = 2'b11,
        MP_DONE = 2'b10
    } wfd_mp_state_type;

endpackage : wfd_pkg

// [wfd_wake_detect.sv]
// Wake-up frame and magic packet detector with APB register port
`timescale 1ns/1ps

// Summary of operation
// - Mask bit j (0 to 30) feeds frame byte offset+j into the filter CRC.
// - Command address-type bit picks multicast-only or unicast-only frames.
// - A filter never matches while its command enable bit is clear.
// - Byte position zero is the first destination address byte.
// - Computed CRC-16 equal to the expected value marks a wake frame.
// - Magic enable suppresses normal reception while data is scanned.
// - Magic detection can drive the interrupt or power event output.
// - Magic detection sets the magic received flag.
// - Clearing magic enable restores normal reception.
// - Magic check applies to own unicast or broadcast destinations.
// - Sync search of six 0xff bytes starts after both address fields.
// - Sync followed by sixteen station address copies is a magic packet.
// - Multicast frames also qualify as magic packets.
// - In full power, magic detection needs the magic enable bit.
// - Low power state enables both detections regardless of enable bits.
// - Wake enable suppresses normal reception; clearing it restores reception.
// - Wake frame detection sets its flag and can signal interrupt or event.
// - Four independent filters each need address filtering and CRC match.
module wfd_wake_detect #(
    parameter int MAGIC_REPS = wfd_pkg::MAGIC_REPS,
    parameter int SYNC_LEN   = wfd_pkg::SYNC_LEN
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire wfd_pkg::wfd_rx_byte_type rx_in,
    input  wire logic                     low_power_state,
    output logic                          rx_normal_enable,
    output logic                          irq,
    output logic                          power_event_output
);
    import wfd_pkg::*;

    // ---------------------------------------------------------------
    // Elaboration check
    // ---------------------------------------------------------------
    if (MAGIC_REPS < 1 || MAGIC_REPS > 16 || SYNC_LEN < 1 || SYNC_LEN > 7) begin : g_bad_param
        $error("wfd_wake_detect: MAGIC_REPS or SYNC_LEN out of range");
    end

    localparam logic [3:0] LAST_REP  = 4'(MAGIC_REPS - 1);
    localparam logic [2:0] SYNC_FULL = 3'(SYNC_LEN);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [31:0]      mask_q [NUM_FILTERS];
    logic [3:0]       cmd_q  [NUM_FILTERS];
    logic [7:0]       off_q  [NUM_FILTERS];
    logic [15:0]      exp_q  [NUM_FILTERS];
    logic [15:0]      crc_q  [NUM_FILTERS];
    logic [15:0]      crc_d  [NUM_FILTERS];
    logic [NUM_FILTERS-1:0] wf_hit;
    logic             magic_packet_enable_q, wake_frame_enable_q, mpr_q, wake_frame_received_flag_q;
    logic [3:0]       notify_q;
    logic [31:0]      addr_lo_q;
    logic [15:0]      addr_hi_q;
    logic [31:0]      prdata_q;
    logic [31:0]      rd_data;
    logic             addr_hit;
    logic             wr_en;
    logic             irq_q, pme_q;
    logic [10:0]      pos_q, cur_pos;
    logic [47:0]      da_q, station;
    logic             dest_mcast, dest_bcast, dest_own;
    logic             mp_active, wf_active, mp_found, wf_frame_hit;
    wfd_mp_state_type mp_state_q;
    logic [2:0]       run_q, bidx_q;
    logic [3:0]       rep_q;
    logic [7:0]       exp_byte;
    logic             byte_in;

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    always_comb begin
        addr_hit = 1'b1;
        rd_data  = RST_WORD;
        case (paddr)
            OFS_MASK0:       rd_data = mask_q[0];
            OFS_MASK0 + 12'h004: rd_data = mask_q[1];
            OFS_MASK0 + 12'h008: rd_data = mask_q[2];
            OFS_MASK0 + 12'h00c: rd_data = mask_q[3];
            OFS_CMD:         rd_data = {4'h0, cmd_q[3], 4'h0, cmd_q[2], 4'h0, cmd_q[1], 4'h0, cmd_q[0]};
            OFS_OFFSET:      rd_data = {off_q[3], off_q[2], off_q[1], off_q[0]};
            OFS_CRC01:       rd_data = {exp_q[1], exp_q[0]};
            OFS_CRC23:       rd_data = {exp_q[3], exp_q[2]};
            OFS_WCSR:        rd_data = {20'h0_0000, notify_q, 2'h0, wake_frame_received_flag_q, mpr_q, 1'b0, wake_frame_enable_q, magic_packet_enable_q, 1'b0};
            OFS_ADDR_LO:     rd_data = addr_lo_q;
            OFS_ADDR_HI:     rd_data = {16'h0000, addr_hi_q};
            default:         addr_hit = 1'b0;
        endcase
    end

    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;
    assign prdata  = prdata_q;
    assign wr_en   = psel & penable & pready & pwrite & addr_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RST_WORD;
        end else if (psel && !penable) begin
            prdata_q <= rd_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_FILTERS; i++) begin
                mask_q[i] <= RST_WORD;
                cmd_q[i]  <= 4'h0;
                off_q[i]  <= 8'h00;
                exp_q[i]  <= 16'h0000;
            end
            addr_lo_q <= RST_WORD;
            addr_hi_q <= 16'h0000;
            magic_packet_enable_q    <= 1'b0;
            wake_frame_enable_q    <= 1'b0;
            notify_q  <= 4'h0;
        end else if (wr_en) begin
            for (int i = 0; i < NUM_FILTERS; i++) begin
                if (paddr == OFS_MASK0 + 12'(4 * i)) begin
                    mask_q[i] <= pwdata;
                end
                if (paddr == OFS_CMD) begin
                    cmd_q[i] <= pwdata[i*CMD_STRIDE +: 4];
                end
                if (paddr == OFS_OFFSET) begin
                    off_q[i] <= pwdata[i*OFS_STRIDE +: 8];
                end
                if (paddr == (i < 2 ? OFS_CRC01 : OFS_CRC23)) begin
                    exp_q[i] <= pwdata[(i % 2)*CRC_STRIDE +: 16];
                end
            end
            if (paddr == OFS_ADDR_LO) begin
                addr_lo_q <= pwdata;
            end
            if (paddr == OFS_ADDR_HI) begin
                addr_hi_q <= pwdata[15:0];
            end
            if (paddr == OFS_WCSR) begin
                magic_packet_enable_q   <= pwdata[WCSR_MAGIC_PACKET_ENABLE];
                wake_frame_enable_q   <= pwdata[WCSR_WAKE_FRAME_ENABLE];
                notify_q <= pwdata[WCSR_WF_PME:WCSR_MP_IRQ];
            end
        end
    end

    // ---------------------------------------------------------------
    // Status flags: write one to clear, a detection in the same cycle wins
    // ---------------------------------------------------------------
    logic clr_mpr, clr_wake_frame_received_flag;
    assign clr_mpr  = wr_en & (paddr == OFS_WCSR) & pwdata[WCSR_MPR];
    assign clr_wake_frame_received_flag = wr_en & (paddr == OFS_WCSR) & pwdata[WCSR_WAKE_FRAME_RECEIVED_FLAG];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mpr_q  <= 1'b0;
            wake_frame_received_flag_q <= 1'b0;
        end else begin
            mpr_q  <= mp_found | (mpr_q & ~clr_mpr);
            wake_frame_received_flag_q <= wf_frame_hit | (wake_frame_received_flag_q & ~clr_wake_frame_received_flag);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            pme_q <= 1'b0;
        end else begin
            irq_q <= (mpr_q & notify_q[0]) | (wake_frame_received_flag_q & notify_q[2]);
            pme_q <= (mpr_q & notify_q[1]) | (wake_frame_received_flag_q & notify_q[3]);
        end
    end

    assign irq                = irq_q;
    assign power_event_output = pme_q;

    // ---------------------------------------------------------------
    // Mode control
    // ---------------------------------------------------------------
    assign mp_active        = magic_packet_enable_q | low_power_state;
    assign wf_active        = wake_frame_enable_q | low_power_state;
    assign rx_normal_enable = ~(magic_packet_enable_q | wake_frame_enable_q | low_power_state);

    // ---------------------------------------------------------------
    // Frame position and destination capture
    // ---------------------------------------------------------------
    assign byte_in = rx_in.valid;
    assign cur_pos = rx_in.sof ? 11'h000 : pos_q;
    assign station = {addr_hi_q, addr_lo_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 11'h000;
            da_q  <= 48'h0000_0000_0000;
        end else if (byte_in) begin
            pos_q <= (cur_pos == POS_MAX) ? POS_MAX : cur_pos + 11'h001;
            if (cur_pos < DA_LEN) begin
                da_q[cur_pos[2:0]*8 +: 8] <= rx_in.data;
            end
        end
    end

    // Bit 0 of the first byte on the wire marks a group address
    assign dest_mcast = da_q[0];
    assign dest_bcast = &da_q;
    assign dest_own   = (da_q == station);

    // ---------------------------------------------------------------
    // Magic packet scanner
    // ---------------------------------------------------------------
    assign exp_byte = station[bidx_q*8 +: 8];
    assign mp_found = byte_in & ~rx_in.sof & (mp_state_q == MP_ADDR) & (rx_in.data == exp_byte)
                    & (bidx_q == 3'd5) & (rep_q == LAST_REP) & mp_active
                    & (dest_own | dest_bcast | dest_mcast);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mp_state_q <= MP_IDLE;
            run_q      <= 3'd0;
            bidx_q     <= 3'd0;
            rep_q      <= 4'h0;
        end else if (byte_in) begin
            if (rx_in.sof || cur_pos < HDR_LEN) begin
                mp_state_q <= MP_IDLE;
                run_q      <= 3'd0;
                bidx_q     <= 3'd0;
                rep_q      <= 4'h0;
            end else begin
                case (mp_state_q)
                    MP_IDLE, MP_SYNC: begin
                        if (rx_in.data == SYNC_BYTE) begin
                            run_q      <= run_q + 3'd1;
                            mp_state_q <= (run_q + 3'd1 == SYNC_FULL) ? MP_ADDR : MP_SYNC;
                        end else begin
                            run_q      <= 3'd0;
                            mp_state_q <= MP_SYNC;
                        end
                    end
                    MP_ADDR: begin
                        if (rx_in.data == exp_byte) begin
                            bidx_q <= (bidx_q == 3'd5) ? 3'd0 : bidx_q + 3'd1;
                            if (bidx_q == 3'd5) begin
                                rep_q <= rep_q + 4'h1;
                                if (rep_q == LAST_REP) begin
                                    mp_state_q <= MP_DONE;
                                end
                            end
                        end else if (rx_in.data == SYNC_BYTE && bidx_q == 3'd0 && rep_q == 4'h0) begin
                            // A longer sync run keeps the scanner armed
                            mp_state_q <= MP_ADDR;
                        end else begin
                            // A broken copy restarts the sync search at this byte
                            mp_state_q <= MP_SYNC;
                            run_q      <= (rx_in.data == SYNC_BYTE) ? 3'd1 : 3'd0;
                            bidx_q     <= 3'd0;
                            rep_q      <= 4'h0;
                        end
                    end
                    MP_DONE: mp_state_q <= MP_DONE;
                    default: mp_state_q <= MP_IDLE;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Wake-up filters
    // ---------------------------------------------------------------
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int b = 7; b >= 0; b--) begin
            r = (r[15] ^ d[b]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction : crc16_byte

    for (genvar i = 0; i < NUM_FILTERS; i++) begin : g_filter
        logic [10:0] rel;
        logic        feed;
        logic [15:0] base;
        assign rel  = cur_pos - {3'b000, off_q[i]};
        // Bit 31 of the mask never selects a byte
        assign feed = byte_in & (cur_pos >= {3'b000, off_q[i]}) & (rel < 11'(MASK_BITS))
                    & mask_q[i][rel[4:0]];
        assign base = rx_in.sof ? CRC_PRESET : crc_q[i];
        assign crc_d[i] = feed ? crc16_byte(base, rx_in.data) : base;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                crc_q[i] <= CRC_PRESET;
            end else if (byte_in) begin
                crc_q[i] <= crc_d[i];
            end
        end

        // Verdict on the last byte; unicast frames must carry the own address
        assign wf_hit[i] = byte_in & rx_in.eof & cmd_q[i][CMD_EN_BIT]
                         & (cmd_q[i][CMD_MCAST_BIT] == dest_mcast)
                         & (dest_mcast | dest_own)
                         & (crc_d[i] == exp_q[i]);
    end

    assign wf_frame_hit = (|wf_hit) & wf_active;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_mpr_set;
        mp_found |=> mpr_q;
    endproperty
    a_mpr_set: assert property (p_mpr_set) else $error("magic flag not set");

    property p_wake_frame_received_flag_set;
        wf_frame_hit |=> wake_frame_received_flag_q;
    endproperty
    a_wake_frame_received_flag_set: assert property (p_wake_frame_received_flag_set) else $error("wake flag not set");

    property p_magic_gate;
        mp_found |-> (magic_packet_enable_q || low_power_state) && (dest_own || dest_bcast || dest_mcast);
    endproperty
    a_magic_gate: assert property (p_magic_gate) else $error("magic found while off");

    property p_filter_en;
        (wf_hit != '0) |-> (wf_hit & ~{cmd_q[3][0], cmd_q[2][0], cmd_q[1][0], cmd_q[0][0]}) == '0;
    endproperty
    a_filter_en: assert property (p_filter_en) else $error("disabled filter hit");

    property p_addr_type;
        wf_hit[0] |-> cmd_q[0][CMD_MCAST_BIT] == da_q[0];
    endproperty
    a_addr_type: assert property (p_addr_type) else $error("address type mismatch");

    property p_crc_cmp;
        wf_hit[0] |=> crc_q[0] == exp_q[0];
    endproperty
    a_crc_cmp: assert property (p_crc_cmp) else $error("crc mismatch on hit");

    property p_rx_suppress;
        (magic_packet_enable_q || wake_frame_enable_q) |-> !rx_normal_enable;
    endproperty
    a_rx_suppress: assert property (p_rx_suppress) else $error("rx not suppressed");

    property p_rx_restore;
        $fell(magic_packet_enable_q) && !wake_frame_enable_q && !low_power_state |-> rx_normal_enable;
    endproperty
    a_rx_restore: assert property (p_rx_restore) else $error("rx not restored");

    property p_irq;
        mp_found && notify_q[0] |=> ##1 irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    property p_pos;
        byte_in && rx_in.sof |=> pos_q == 11'h001;
    endproperty
    a_pos: assert property (p_pos) else $error("position not restarted");

    c_magic:   cover property (mp_found);
    c_wake:    cover property (wf_frame_hit);
    c_collide: cover property (mp_found && clr_mpr);

endmodule : wfd_wake_detect

// [wfd_rx_model.sv]
// Receive datapath model: plays queued frames into the detector, one byte per clock
`timescale 1ns/1ps
module wfd_rx_model (
    input  wire logic                pclk,
    output wfd_pkg::wfd_rx_byte_type rx_in
);
    import wfd_pkg::*;

    initial rx_in = '0;

    // ------------------------------------------------
    // Frame playback
    // ------------------------------------------------
    task automatic send(input logic [7:0] q[$]);
        for (int i = 0; i < q.size(); i++) begin
            @(posedge pclk);
            rx_in <= '{1'b1, i == 0, i == q.size() - 1, q[i]};
        end
        @(posedge pclk);
        // Idle bytes carry inverted data so a stale byte can never look valid
        rx_in <= '{1'b0, 1'b0, 1'b0, ~q[q.size() - 1]};
    endtask : send
endmodule : wfd_rx_model

// [tb_top.sv]
// Self-checking bench for the wake detector: APB register tasks and frame scenarios
`timescale 1ns/1ps
module tb_top;
    import wfd_pkg::*;

    // ------------------------------------------------
    // Signals
    // ------------------------------------------------
    logic            pclk = 1'b0;
    logic            presetn = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic            low_power_state = 1'b0;
    logic [11:0]     paddr = 12'h000;
    logic [31:0]     pwdata = 32'h0000_0000;
    logic [31:0]     prdata;
    logic            pready, pslverr, rx_normal_enable, irq, power_event_output;
    wfd_rx_byte_type rx_in;
    logic [7:0]      fr[$];
    logic [47:0]     sta = 48'h0a0b_0c0d_0e02;
    int              n_errors = 0;
    int              compares = 0;

    always #5 pclk = ~pclk;

    wfd_wake_detect wfd_wake_detect_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_in(rx_in), .low_power_state(low_power_state), .rx_normal_enable(rx_normal_enable), .irq(irq),
        .power_event_output(power_event_output));
    wfd_rx_model wfd_rx_model_inst (.pclk(pclk), .rx_in(rx_in));

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic end_sim();
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait that never sees pready
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rdchk

    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle

    // Header, sync run, station address copies, then filler that never resembles either
    task automatic mk(input logic [47:0] da, input int reps);
        fr = {};
        for (int k = 0; k < 6; k++) fr.push_back(da[8*k+:8]);
        for (int k = 0; k < 6; k++) fr.push_back(8'h20 + 8'(k));
        repeat (6) fr.push_back(8'hff);
        repeat (reps) for (int k = 0; k < 6; k++) fr.push_back(sta[8*k+:8]);
        for (int k = 0; k < 40; k++) fr.push_back(8'h40 + 8'(k));
    endtask : mk

    function automatic logic [15:0] crc16(input logic [7:0] q[$], input logic [7:0] ofs, input logic [30:0] m);
        logic [15:0] c;
        c = 16'hffff;
        for (int j = 0; j < 31; j++)
            if (m[j])
                for (int b = 7; b >= 0; b--)
                    c = {c[14:0], 1'b0} ^ ((c[15] ^ q[ofs + j][b]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction : crc16

    task automatic run(input logic [31:0] cfg, input logic lp, input logic [47:0] da, input int reps,
                       input int fb, input logic hit);
        wr(OFS_WCSR, cfg);
        low_power_state <= lp;
        settle();
        chk(rx_normal_enable, !(cfg[WCSR_MAGIC_PACKET_ENABLE] | cfg[WCSR_WAKE_FRAME_ENABLE] | lp));
        mk(da, reps);
        wfd_rx_model_inst.send(fr);
        settle();
        rdchk(OFS_WCSR, cfg | (32'(hit) << fb));
        chk({irq, power_event_output}, {hit, hit});
        wr(OFS_WCSR, 32'h0000_0030);
        low_power_state <= 1'b0;
        settle();
        chk({irq, rx_normal_enable}, 2'b01);
    endtask : run

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    initial begin
        logic [31:0] r;
        logic        e;
        logic [15:0] c;
        logic [47:0] md[7];
        logic [47:0] wd[6];
        logic [3:0]  cmds[6];
        logic [6:0]  mhit;
        logic [5:0]  whit;
        mhit = 7'b1000111;
        whit = 6'b001001;
        md   = '{sta, 48'hffff_ffff_ffff, 48'h0a0b_0c0d_0e03, 48'h0a0b_0c0d_0e04, sta, sta, sta};
        wd   = '{sta, sta, sta, 48'h0a0b_0c0d_0e03, sta, 48'h0a0b_0c0d_0e04};
        cmds = '{4'h1, 4'h0, 4'h9, 4'h9, 4'h1, 4'h1};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFS_WCSR, 32'h0);
        chk(rx_normal_enable, 1'b1);
        apb(1'b0, 12'h0fc, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        wr(OFS_ADDR_LO, sta[31:0]);
        wr(OFS_ADDR_HI, {16'h0, sta[47:32]});
        // Own, broadcast, multicast, foreign, short, disabled, low power
        for (int i = 0; i < 7; i++)
            run(32'hf00 | (32'(i < 5) << WCSR_MAGIC_PACKET_ENABLE), i == 6, md[i], 16 - (i == 4), WCSR_MPR,
                mhit[i]);
        // One filter at a time, rotating through all four; bit 31 of the mask set on purpose
        for (int i = 0; i < 6; i++) begin
            mk(wd[i], 0);
            c = crc16(fr, 8'(12 + i), 31'h5a5a_0f0f) ^ {15'h0, i == 4};
            for (int f = 0; f < 4; f++) wr(OFS_MASK0 + 12'(4 * f), 32'hda5a_0f0f);
            wr(OFS_CMD, 32'(cmds[i]) << (8 * (i % 4)));
            wr(OFS_OFFSET, {4{8'(12 + i)}});
            wr(OFS_CRC01, {c, c});
            wr(OFS_CRC23, {c, c});
            // Filter 3 runs in low power with the wake enable clear
            run(32'hf00 | (32'(i != 3) << WCSR_WAKE_FRAME_ENABLE), i == 3, wd[i], 0, WCSR_WAKE_FRAME_RECEIVED_FLAG,
                whit[i]);
        end
        end_sim();
    end

    initial begin
        #200_000;
        n_errors++;
        end_sim();
    end
endmodule : tb_top
